// [verilog/dmd_map.svh]
// address map, reset values and timing counts of the memory space decoder
`ifndef DMD_MAP_SVH
`define DMD_MAP_SVH

`define DMD_ADDR_W          20
`define DMD_DATA_W          32
`define DMD_WORD_W          16
`define DMD_SHARED_TOP      4'hF
`define DMD_EIO_BASE        11'h700
`define DMD_SLICE_ARB       4'h0
`define DMD_SLICE_SSP       4'h3
`define DMD_SLICE_IPC       4'h7
`define DMD_CTRL_OFFSET     12'h000
`define DMD_CTRL_ADDR       20'hF0000
`define DMD_CTRL_RESET      16'h0FFF
`define DMD_CTRL_WAIT_LSB   0
`define DMD_CTRL_WAIT_W     4
`define DMD_SSP_LAST        12'h010
`define DMD_IPC_WORDS       12'h400
`define DMD_WR_MIN_CYC      2
`define DMD_RD_MIN_CYC      5

`endif

// [verilog/dmd_pkg.sv]
// types shared by the memory space decoder modules
package dmd_pkg;
    typedef enum logic {
        dmd_side_x,
        dmd_side_y
    } dmd_side_t;

    typedef enum logic [1:0] {
        dmd_st_idle,
        dmd_st_busy,
        dmd_st_done
    } dmd_arb_state_t;
endpackage

// [verilog/dmd_arb_if.sv]
// link between the decoder top and its system bus arbiter
`timescale 1ns/1ps
interface dmd_arb_if;
    import dmd_pkg::*;
    logic            x_req;
    logic            y_req;
    logic            x_we;
    logic            y_we;
    logic [3:0]      extra_wait;
    logic            bus_gnt;
    dmd_side_t       owner;
    logic            busy;
    logic            last;
    logic            done;

    modport top (output x_req, y_req, x_we, y_we, extra_wait, bus_gnt,
                 input owner, busy, last, done);
    modport arb (input x_req, y_req, x_we, y_we, extra_wait, bus_gnt,
                 output owner, busy, last, done);
endinterface

// [verilog/dmd_sysbus_arb.sv]
// serialises shared region accesses and counts their wait-states
`timescale 1ns/1ps
`include "dmd_map.svh"
module dmd_sysbus_arb
    import dmd_pkg::*;
#(
    parameter int WR_CYC = `DMD_WR_MIN_CYC,
    parameter int RD_CYC = `DMD_RD_MIN_CYC
) (
    input  wire logic  core_clk_i,
    input  wire logic  resetn_i,
    dmd_arb_if.arb     arb
);
    if (WR_CYC < 1 || WR_CYC > 8 || RD_CYC < 1 || RD_CYC > 8) begin : g_bad_cyc
        $error("dmd_sysbus_arb: cycle counts must lie in 1..8");
    end

    dmd_arb_state_t state;
    dmd_arb_state_t next_state;
    dmd_side_t      next_owner;
    logic [4:0]     cnt;
    logic [4:0]     next_cnt;
    logic           last_y;
    logic           next_last_y;
    logic           owner_we;
    logic [4:0]     tgt;
    logic [4:0]     acc_len;
    logic [4:0]     next_acc_len;

    function automatic logic [4:0] cyc_target(input logic we, input logic [3:0] extra);
        cyc_target = (we ? 5'(WR_CYC) : 5'(RD_CYC)) + {1'b0, extra};
    endfunction

    assign owner_we = (arb.owner == dmd_side_y) ? arb.y_we : arb.x_we;
    assign tgt      = cyc_target(owner_we, arb.extra_wait);
    assign arb.busy = (state == dmd_st_busy);
    assign arb.last = arb.busy && arb.bus_gnt && (cnt == tgt - 5'h01);
    assign arb.done = (state == dmd_st_done);

    always_comb begin
        next_state  = state;
        next_owner  = arb.owner;
        next_cnt    = cnt;
        next_last_y = last_y;
        case (state)
            dmd_st_idle: begin
                next_cnt = 5'h00;
                if (arb.x_req && (!arb.y_req || last_y)) begin
                    next_owner = dmd_side_x;
                    next_state = dmd_st_busy;
                end else if (arb.y_req) begin
                    next_owner = dmd_side_y;
                    next_state = dmd_st_busy;
                end
            end
            dmd_st_busy: begin
                if (arb.last) begin
                    next_state  = dmd_st_done;
                    next_last_y = (arb.owner == dmd_side_y);
                end else if (arb.bus_gnt) begin
                    next_cnt = cnt + 5'h01;
                end
            end
            dmd_st_done: next_state = dmd_st_idle;
            default:     next_state = dmd_st_idle;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state     <= dmd_st_idle;
            arb.owner <= dmd_side_x;
            cnt       <= 5'h00;
            last_y    <= 1'b0;
        end else begin
            state     <= next_state;
            arb.owner <= next_owner;
            cnt       <= next_cnt;
            last_y    <= next_last_y;
        end
    end

    // cycles spent inside the current access, for checking only
    always_comb begin
        next_acc_len = acc_len;
        if (state == dmd_st_idle) begin
            next_acc_len = 5'h00;
        end else if (acc_len != 5'h1F) begin
            next_acc_len = acc_len + 5'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_len <= 5'h00;
        end else begin
            acc_len <= next_acc_len;
        end
    end

    AST_WR_MIN_CYCLES: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        arb.done && owner_we |-> acc_len >= 5'(WR_CYC))
        else $error("shared write completed too early");
    AST_RD_MIN_CYCLES: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        arb.done && !owner_we |-> acc_len >= 5'(RD_CYC))
        else $error("shared read completed too early");
    AST_CONTENDED_HOLD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        arb.busy && !arb.bus_gnt |=> !arb.done)
        else $error("access completed while bus withheld");
    AST_ONE_OWNER: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        arb.busy && $past(arb.busy) |-> arb.owner == $past(arb.owner))
        else $error("owner changed during an access");
endmodule

// [verilog/dmd_decoder.sv]
// memory space decoder for the signal-processor core
// Functional notes
// - X or Y space is chosen by the issuing addressing unit, not the address.
// - X port has a 20-bit address and a 32-bit data bus.
// - Y port has a 20-bit address and a 32-bit data bus.
// - 16-bit word addressing; single-word and two-word 32-bit transfers.
// - 64 Kword shared region reachable from X and Y, always via system bus.
// - Shared writes take at least two core clock cycles.
// - Shared reads take at least five core clock cycles.
// - Core stalls during shared accesses, longer when the bus is contended.
// - Shared region splits into sixteen 4 Kword peripheral selects.
// - Slice 0 arbiter registers, slice 3 serial port, slice 7 interprocessor memory.
// - Interprocessor dual-port memory holds 1 Kword.
// - External select covers 512 words at 0xE0000, Y space only.
// - Arbiter control register at region base, 16 bits, resets to 0x0FFF.
`timescale 1ns/1ps
`include "dmd_map.svh"
module dmd_decoder
    import dmd_pkg::*;
(
    input  wire logic                    core_clk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    x_req_i,
    input  wire logic                    x_we_i,
    input  wire logic                    x_wide_i,
    input  wire logic [`DMD_ADDR_W-1:0]  x_space_address_bus_i,
    input  wire logic [`DMD_DATA_W-1:0]  x_space_data_bus_wr_i,
    output logic      [`DMD_DATA_W-1:0]  x_space_data_bus_rd_o,
    output logic                         x_wait_o,
    output logic                         x_priv_sel_o,
    input  wire logic                    y_req_i,
    input  wire logic                    y_we_i,
    input  wire logic                    y_wide_i,
    input  wire logic [`DMD_ADDR_W-1:0]  y_space_address_bus_i,
    input  wire logic [`DMD_DATA_W-1:0]  y_space_data_bus_wr_i,
    output logic      [`DMD_DATA_W-1:0]  y_space_data_bus_rd_o,
    output logic                         y_wait_o,
    output logic                         y_priv_sel_o,
    output logic                         external_io_window_sel_o,
    input  wire logic                    sb_gnt_i,
    input  wire logic [`DMD_DATA_W-1:0]  sb_rdata_i,
    output logic                         sb_req_o,
    output logic                         sb_we_o,
    output logic                         sb_wide_o,
    output logic      [15:0]             sb_addr_o,
    output logic      [`DMD_DATA_W-1:0]  sb_wdata_o,
    output logic      [15:0]             periph_sel_o
);
    dmd_arb_if arb_if ();

    logic                    x_shared;
    logic                    y_shared;
    logic                    y_eio;
    logic                    own_y;
    logic [`DMD_ADDR_W-1:0]  a_addr;
    logic [`DMD_DATA_W-1:0]  a_wdata;
    logic                    a_we;
    logic                    a_wide;
    logic [3:0]              a_slice;
    logic [11:0]             a_off;
    logic [`DMD_DATA_W-1:0]  rd_word;
    logic [`DMD_WORD_W-1:0]  external_arbiter_control;
    logic [`DMD_WORD_W-1:0]  next_external_arbiter_control;
    logic [`DMD_DATA_W-1:0]  next_x_rdata;
    logic [`DMD_DATA_W-1:0]  next_y_rdata;

    function automatic logic is_shared(input logic [`DMD_ADDR_W-1:0] addr);
        is_shared = (addr[19:16] == `DMD_SHARED_TOP);
    endfunction

    // populated words inside a slice; all else is reserved
    function automatic logic populated(input logic [3:0] slice, input logic [11:0] off);
        case (slice)
            `DMD_SLICE_ARB: populated = (off == `DMD_CTRL_OFFSET);
            `DMD_SLICE_SSP: populated = (off <= `DMD_SSP_LAST);
            `DMD_SLICE_IPC: populated = (off < `DMD_IPC_WORDS);
            default:        populated = 1'b0;
        endcase
    endfunction

    // space comes from the port used, never from the address
    assign x_shared = x_req_i && is_shared(x_space_address_bus_i);
    assign y_shared = y_req_i && is_shared(y_space_address_bus_i);
    assign y_eio    = y_req_i && (y_space_address_bus_i[19:9] == `DMD_EIO_BASE);

    assign x_priv_sel_o             = x_req_i && !x_shared;
    assign y_priv_sel_o             = y_req_i && !y_shared && !y_eio;
    assign external_io_window_sel_o = y_eio;

    assign arb_if.x_req      = x_shared;
    assign arb_if.y_req      = y_shared;
    assign arb_if.x_we       = x_we_i;
    assign arb_if.y_we       = y_we_i;
    assign arb_if.bus_gnt    = sb_gnt_i;
    assign arb_if.extra_wait =
        external_arbiter_control[`DMD_CTRL_WAIT_LSB +: `DMD_CTRL_WAIT_W];

    dmd_sysbus_arb #(
        .WR_CYC (`DMD_WR_MIN_CYC),
        .RD_CYC (`DMD_RD_MIN_CYC)
    ) u_arb (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .arb        (arb_if.arb)
    );

    // owner's request onto the system bus
    assign own_y   = (arb_if.owner == dmd_side_y);
    assign a_addr  = own_y ? y_space_address_bus_i : x_space_address_bus_i;
    assign a_wdata = own_y ? y_space_data_bus_wr_i : x_space_data_bus_wr_i;
    assign a_we    = own_y ? y_we_i : x_we_i;
    assign a_wide  = own_y ? y_wide_i : x_wide_i;
    assign a_slice = a_addr[15:12];
    assign a_off   = a_addr[11:0];

    assign sb_req_o     = arb_if.busy;
    assign sb_we_o      = arb_if.busy && a_we;
    assign sb_wide_o    = arb_if.busy && a_wide;
    assign sb_addr_o    = a_addr[15:0];
    assign sb_wdata_o   = a_wdata;
    assign periph_sel_o = arb_if.busy ? (16'h0001 << a_slice) : 16'h0000;

    // lower word in bits 15:0, next word up in bits 31:16
    always_comb begin
        rd_word = '0;
        if (a_slice == `DMD_SLICE_ARB) begin
            if (a_off == `DMD_CTRL_OFFSET) begin
                rd_word[15:0] = external_arbiter_control;
            end
        end else if (populated(a_slice, a_off)) begin
            rd_word[15:0] = sb_rdata_i[15:0];
            if (a_wide && populated(a_slice, a_off + 12'h001)) begin
                rd_word[31:16] = sb_rdata_i[31:16];
            end
        end
    end

    always_comb begin
        next_external_arbiter_control = external_arbiter_control;
        next_x_rdata                  = x_space_data_bus_rd_o;
        next_y_rdata                  = y_space_data_bus_rd_o;
        if (arb_if.last) begin
            if (a_we) begin
                if (a_slice == `DMD_SLICE_ARB && a_off == `DMD_CTRL_OFFSET) begin
                    next_external_arbiter_control = a_wdata[15:0];
                end
            end else if (own_y) begin
                next_y_rdata = rd_word;
            end else begin
                next_x_rdata = rd_word;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            external_arbiter_control <= `DMD_CTRL_RESET;
            x_space_data_bus_rd_o    <= 32'h00000000;
            y_space_data_bus_rd_o    <= 32'h00000000;
        end else begin
            external_arbiter_control <= next_external_arbiter_control;
            x_space_data_bus_rd_o    <= next_x_rdata;
            y_space_data_bus_rd_o    <= next_y_rdata;
        end
    end

    // stall each port until its own access is done
    assign x_wait_o = x_shared && !(arb_if.done && !own_y);
    assign y_wait_o = y_shared && !(arb_if.done && own_y);

    AST_X_NEVER_EIO: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        external_io_window_sel_o |-> y_req_i && !y_shared && !y_priv_sel_o)
        else $error("external window selected outside Y space");
    AST_X_ROUTE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        x_req_i |-> (x_priv_sel_o != x_shared))
        else $error("X access routed twice or not at all");
    AST_X_STALL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        x_shared && !arb_if.busy && !arb_if.done |-> x_wait_o)
        else $error("X core not stalled on shared access");
    AST_ONE_SELECT: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sb_req_o |-> $onehot(periph_sel_o) && periph_sel_o[a_slice])
        else $error("peripheral select not one-hot on slice");
    AST_RSVD_ZERO: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        arb_if.last && !a_we && !own_y && !populated(a_slice, a_off)
        |=> x_space_data_bus_rd_o == 32'h00000000)
        else $error("reserved read returned nonzero data");
    AST_BOTH_SERIAL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        x_shared && y_shared |-> x_wait_o || y_wait_o)
        else $error("X and Y shared accesses released together");
    AST_CTRL_WRITE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        arb_if.last && a_we && a_slice == `DMD_SLICE_ARB && a_off == `DMD_CTRL_OFFSET
        |=> external_arbiter_control == $past(a_wdata[15:0]))
        else $error("control register did not take the write");
    AST_CTRL_HOLD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !(arb_if.last && a_we) |=> $stable(external_arbiter_control))
        else $error("control register changed without a write");
    AST_Y_ROUTE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        y_req_i |-> $onehot({y_priv_sel_o, y_shared, external_io_window_sel_o}))
        else $error("Y access routed twice or not at all");
    AST_Y_STALL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        y_shared && !arb_if.busy && !arb_if.done |-> y_wait_o)
        else $error("Y core not stalled on shared access");
    AST_PRIV_NO_STALL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        x_priv_sel_o |-> !x_wait_o)
        else $error("private X access stalled");
    AST_EIO_NO_STALL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        external_io_window_sel_o |-> !y_wait_o)
        else $error("external window access stalled");
    AST_BUS_QUIET: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !arb_if.busy |-> !sb_req_o && periph_sel_o == 16'h0000)
        else $error("system bus driven outside an access");
    AST_RSVD_ZERO_Y: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        arb_if.last && !a_we && own_y && !populated(a_slice, a_off)
        |=> y_space_data_bus_rd_o == 32'h00000000)
        else $error("reserved Y read returned nonzero data");
    AST_WIDE_UPPER: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        arb_if.last && !a_we && a_wide && !populated(a_slice, a_off + 12'h001)
        |=> (own_y ? y_space_data_bus_rd_o[31:16] : x_space_data_bus_rd_o[31:16]) == 16'h0000)
        else $error("wide read kept data of an empty upper word");
endmodule

// [verification/dmd_periph_model.sv]
// behavioural peripherals on the shared system bus
`timescale 1ns/1ps
module dmd_periph_model (
    input  wire logic        core_clk_i,
    input  wire logic        sb_req_i,
    input  wire logic        sb_we_i,
    input  wire logic        sb_wide_i,
    input  wire logic [15:0] sb_addr_i,
    input  wire logic [31:0] sb_wdata_i,
    input  wire logic [15:0] periph_sel_i,
    output logic      [31:0] sb_rdata_o
);
    logic [15:0] mem [0:2047];
    logic [31:0] idle_pat = 32'h5A5AA5A5;
    logic [15:0] nxt;
    // populated words only answer while their slice is selected
    function automatic logic pop(input logic [15:0] a);
        return periph_sel_i[a[15:12]] && ((a[15:12] == 4'h3 && a[11:0] <= 12'h010)
            || (a[15:12] == 4'h7 && a[11:0] < 12'h400));
    endfunction
    function automatic logic [15:0] rd(input logic [15:0] a);
        return pop(a) ? mem[{a[14], a[10:0]}] : 16'h0000;
    endfunction
    assign nxt = sb_addr_i + 16'h0001;
    always_ff @(posedge core_clk_i) begin
        idle_pat <= ~idle_pat;
        if (sb_req_i && sb_we_i && pop(sb_addr_i)) begin
            mem[{sb_addr_i[14], sb_addr_i[10:0]}] <= sb_wdata_i[15:0];
        end
        if (sb_req_i && sb_we_i && sb_wide_i && pop(nxt)) begin
            mem[{nxt[14], nxt[10:0]}] <= sb_wdata_i[31:16];
        end
    end
    // released bus shows a toggling pattern, narrow reads too in the upper half
    always_comb begin
        sb_rdata_o = idle_pat;
        if (sb_req_i) begin
            sb_rdata_o = {sb_wide_i ? rd(nxt) : idle_pat[31:16], rd(sb_addr_i)};
        end
    end
endmodule

// [verification/dsp_memory_space_decoder_test.sv]
// directed tests of the memory space decoder
`timescale 1ns/1ps
module dsp_memory_space_decoder_test;
    logic        clk, resetn, gnt, x_req, x_we, x_wide, y_req, y_we, y_wide;
    logic [19:0] x_a, y_a;
    logic [31:0] x_wd, y_wd, x_rd, y_rd, sb_rd, sb_wd, rd, rd2;
    logic        x_wait, y_wait, x_pv, y_pv, ext, sb_req, sb_we, sb_wide;
    logic [15:0] sb_a, psel, sel;
    int          errors = 0;
    int          n_tests = 0;
    int          n, n2;
    dmd_decoder u_dmd_decoder (.core_clk_i(clk), .resetn_i(resetn), .x_req_i(x_req),
        .x_we_i(x_we), .x_wide_i(x_wide), .x_space_address_bus_i(x_a),
        .x_space_data_bus_wr_i(x_wd), .x_space_data_bus_rd_o(x_rd), .x_wait_o(x_wait),
        .x_priv_sel_o(x_pv), .y_req_i(y_req), .y_we_i(y_we), .y_wide_i(y_wide),
        .y_space_address_bus_i(y_a), .y_space_data_bus_wr_i(y_wd),
        .y_space_data_bus_rd_o(y_rd), .y_wait_o(y_wait), .y_priv_sel_o(y_pv),
        .external_io_window_sel_o(ext), .sb_gnt_i(gnt), .sb_rdata_i(sb_rd),
        .sb_req_o(sb_req), .sb_we_o(sb_we), .sb_wide_o(sb_wide), .sb_addr_o(sb_a),
        .sb_wdata_o(sb_wd), .periph_sel_o(psel));
    dmd_periph_model u_dmd_periph_model (.core_clk_i(clk), .sb_req_i(sb_req),
        .sb_we_i(sb_we), .sb_wide_i(sb_wide), .sb_addr_i(sb_a), .sb_wdata_i(sb_wd),
        .periph_sel_i(psel), .sb_rdata_o(sb_rd));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one core access, entered at a falling edge; counts stalled cycles
    task automatic acc(input logic y, input logic we, input logic wide, input logic [19:0] a,
        input logic [31:0] wd, output logic [31:0] r, output int c, output logic [15:0] s);
        c = 0;
        s = 16'h0000;
        if (y) {y_req, y_we, y_wide, y_a, y_wd} <= {1'b1, we, wide, a, wd};
        else {x_req, x_we, x_wide, x_a, x_wd} <= {1'b1, we, wide, a, wd};
        #1;
        while ((y ? y_wait : x_wait) !== 1'b0 && c < 300) begin
            if (sb_req === 1'b1) s = psel;
            c++;
            @(negedge clk);
            #1;
        end
        if (y) y_req <= 1'b0;
        else x_req <= 1'b0;
        @(negedge clk);
        r = y ? y_rd : x_rd;
    endtask
    task automatic pv(input logic y, input logic [19:0] a, input logic ep, input logic ee);
        if (y) {y_req, y_a} <= {1'b1, a};
        else {x_req, x_a} <= {1'b1, a};
        #1;
        chk("priv_sel", {31'd0, y ? y_pv : x_pv}, {31'd0, ep});
        chk("ext_sel", {31'd0, ext}, {31'd0, ee});
        chk("no_stall", {31'd0, y ? y_wait : x_wait}, 32'd0);
        @(negedge clk);
        {x_req, y_req} <= 2'b00;
        @(negedge clk);
    endtask
    initial begin
        #(40 * 20000);
        errors++;
        close_out();
    end
    initial begin
        {resetn, x_req, x_we, x_wide, y_req, y_we, y_wide} = 7'h00;
        {x_a, y_a, x_wd, y_wd} = '0;
        gnt = 1'b1;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        acc(0, 0, 0, 20'hF0000, 32'h0, rd, n, sel);
        chk("ctrl_reset", {16'h0, rd[15:0]}, 32'h0FFF);
        chk("rd_cyc_max", 32'(n), 32'd21);
        chk("sel_arb", {16'h0, sel}, 32'h0001);
        acc(1, 1, 0, 20'hF0000, 32'h0000A5A0, rd, n, sel);
        chk("wr_cyc_max", 32'(n), 32'd18);
        acc(0, 0, 0, 20'hF0000, 32'h0, rd, n, sel);
        chk("ctrl_rw", {16'h0, rd[15:0]}, 32'hA5A0);
        chk("rd_cyc_min", 32'(n), 32'd6);
        $display("test control done");
        acc(1, 1, 1, 20'hF73FE, 32'h12345678, rd, n, sel);
        chk("wr_cyc_min", 32'(n), 32'd3);
        chk("sel_ipc", {16'h0, sel}, 32'h0080);
        acc(0, 0, 0, 20'hF73FF, 32'h0, rd, n, sel);
        chk("x_word", {16'h0, rd[15:0]}, 32'h1234);
        acc(1, 0, 1, 20'hF73FE, 32'h0, rd, n, sel);
        chk("y_wide", rd, 32'h12345678);
        acc(0, 0, 1, 20'hF73FF, 32'h0, rd, n, sel);
        chk("ipc_edge", rd, 32'h00001234);
        $display("test interprocessor done");
        for (int s = 0; s < 16; s++) begin
            acc(0, 1, 0, {4'hF, 4'(s), 12'h020}, 32'hFFFFFFFF, rd, n, sel);
            acc(0, 0, 0, {4'hF, 4'(s), 12'h020}, 32'h0, rd, n, sel);
            chk("slice_sel", {16'h0, sel}, 32'h1 << s);
            chk("slice_rd", {16'h0, rd[15:0]}, (s == 7) ? 32'hFFFF : 32'h0);
        end
        acc(0, 1, 0, 20'hF3010, 32'h0000BEEF, rd, n, sel);
        acc(1, 0, 0, 20'hF3010, 32'h0, rd, n, sel);
        chk("ssp_rw", {16'h0, rd[15:0]}, 32'hBEEF);
        chk("sel_ssp", {16'h0, sel}, 32'h0008);
        acc(1, 0, 0, 20'hF1000, 32'h0, rd, n, sel);
        chk("y_rsvd", {16'h0, rd[15:0]}, 32'h0);
        $display("test slices done");
        fork
            acc(0, 0, 0, 20'hF7020, 32'h0, rd, n, sel);
            begin
                repeat (2) @(negedge clk);
                gnt <= 1'b0;
                repeat (3) @(negedge clk);
                gnt <= 1'b1;
            end
        join
        chk("contend_cyc", 32'(n), 32'd9);
        chk("contend_rd", {16'h0, rd[15:0]}, 32'hFFFF);
        fork
            acc(0, 0, 0, 20'hF7020, 32'h0, rd, n, sel);
            acc(1, 0, 0, 20'hF73FE, 32'h0, rd2, n2, sel);
        join
        chk("y_first", 32'(n2), 32'd6);
        chk("x_later", {31'd0, n > n2}, 32'd1);
        chk("both_x", {16'h0, rd[15:0]}, 32'hFFFF);
        chk("both_y", {16'h0, rd2[15:0]}, 32'h5678);
        $display("test contention done");
        pv(0, 20'h00100, 1'b1, 1'b0);
        pv(0, 20'hE0000, 1'b1, 1'b0);
        pv(1, 20'hE01FF, 1'b0, 1'b1);
        pv(1, 20'hE0200, 1'b1, 1'b0);
        $display("test selects done");
        close_out();
    end
endmodule
